// ---- tlih_map.svh ----
// Register offsets, field positions, reset values and defaults of the interrupt handler
`ifndef TLIH_MAP_SVH
`define TLIH_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TLIH_OFF_IRQ_ENABLE       8'h00
`define TLIH_OFF_IRQ_ENABLE_EXT   8'h04
`define TLIH_OFF_IRQ_PRIORITY     8'h08
`define TLIH_OFF_IRQ_PRIORITY_EXT 8'h0c
`define TLIH_OFF_TIMER_CONTROL    8'h10
`define TLIH_OFF_EXT_IRQ_CONFIG   8'h14
`define TLIH_OFF_PENDING          8'h18
`define TLIH_OFF_STATUS           8'h1c

// ****************************************************************
// Field positions
// ****************************************************************
`define TLIH_NUM_SRC              12
`define TLIH_IE_GLOBAL            7
`define TLIH_TC_EXT0_TRIG         0
`define TLIH_TC_EXT0_PEND         1
`define TLIH_TC_EXT1_TRIG         2
`define TLIH_TC_EXT1_PEND         3
`define TLIH_CFG_EXT0_SEL_LSB     0
`define TLIH_CFG_EXT0_POL         3
`define TLIH_CFG_EXT1_SEL_LSB     4
`define TLIH_CFG_EXT1_POL         7
`define TLIH_SRC_EXT0             0
`define TLIH_SRC_EXT1             2

// ****************************************************************
// Reset values and parameter defaults
// ****************************************************************
`define TLIH_IP_UNUSED_BITS       2'b11
`define TLIH_CFG_RST              8'h00
`define TLIH_HWCLR_DEFAULT        12'h00f
`define TLIH_VEC_DEFAULT  {16'h005b, 16'h0053, 16'h004b, 16'h0043, 16'h003b, 16'h0033, \
                           16'h002b, 16'h0023, 16'h001b, 16'h0013, 16'h000b, 16'h0003}
`define TLIH_RANK_DEFAULT {4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6, \
                           4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0}

`endif

// ---- tlih_pkg.sv ----
// Types shared by the interrupt handler
package tlih_pkg;

    // ****************************************************************
    // Vector call towards the core
    // ****************************************************************
    typedef struct packed {
        logic        call;   // One-cycle pulse: vector taken
        logic        high;   // Taken routine runs at high level
        logic [3:0]  src;    // Source index taken
        logic [15:0] addr;   // Service address
    } tlih_vec_s;

    // ****************************************************************
    // Whole state of the handler
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  ie;
        logic [5:0]  eie;
        logic [5:0]  ip;
        logic [5:0]  eip;
        logic [1:0]  trig;
        logic [7:0]  cfg;
        logic [11:0] pend;
        logic [1:0]  prev_act;
        logic        in_low;
        logic        in_high;
        logic        hold;
        logic        req;
        logic [3:0]  sel;
        logic        rdy;
        logic        resp;
        logic [31:0] hrdata;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        tlih_vec_s   vec;
    } tlih_state_s;

endpackage : tlih_pkg

// ---- tlih_irq_handler.sv ----
// Two-level interrupt handler with AHB-Lite register slave
// Operation
// - Twelve sources, each at one of two levels
// - Pending flag sets regardless of enable
// - Enabled pending source requests, vector after instruction
// - Return resumes the interrupted instruction stream
// - Disabled pending flag makes no request
// - Per-source enables gated by global enable bit
// - Global clear may still admit one request
// - Vectoring clears only hardware-cleared pending flags
// - Flag still set after return requests again
// - Software writing one acts as event
// - Trigger bit edge/level, polarity bit high/low
// - External inputs watch pins, never disturbing them
// - External pending flags at timer control bits 1,3
// - Edge mode external flag cleared on vectoring
// - Level mode flag follows active input level
// - High preempts low, high never preempted
// - Priority bits reset to low
// - Higher level wins, fixed rank breaks ties
// - Requests sampled and decoded every cycle
// - Equal or lower waits return plus one instruction
`timescale 1ns/1ps
`include "tlih_map.svh"

module tlih_irq_handler #(
    parameter logic [11:0][15:0] SRC_VEC  = `TLIH_VEC_DEFAULT,   // Service addresses
    parameter logic [11:0][3:0]  SRC_RANK = `TLIH_RANK_DEFAULT,  // Tie-break rank
    parameter logic [11:0]       SRC_HWCLR = `TLIH_HWCLR_DEFAULT // Cleared on vectoring
) (
    input  wire logic               hclk,         // System clock
    input  wire logic               hresetn,      // Asynchronous reset, active low
    input  wire logic               hsel,         // AHB slave select
    input  wire logic [31:0]        haddr,        // AHB address
    input  wire logic [1:0]         htrans,       // AHB transfer type
    input  wire logic               hwrite,       // AHB write
    input  wire logic [2:0]         hsize,        // AHB size, word only
    input  wire logic [31:0]        hwdata,       // AHB write data
    input  wire logic               hready,       // AHB bus ready
    output logic                    hreadyout,    // AHB slave ready
    output logic                    hresp,        // AHB response, OKAY
    output logic [31:0]             hrdata,       // AHB read data
    input  wire logic [7:0]         port_pins,    // Port pin levels, watched only
    input  wire logic [11:0]        src_event,    // Peripheral event pulses
    input  wire logic               instr_done,   // Core: instruction completed
    input  wire logic               return_from_interrupt_done,    // Core: return instruction completed
    output logic                    irq_req,      // Request pending towards core
    output tlih_pkg::tlih_vec_s     vector_call   // Vector call to core
);

    // ****************************************************************
    // Reset image and helpers
    // ****************************************************************
    localparam int NSRC = `TLIH_NUM_SRC;

    // Reset image built once; previous-active bits start high so that
    // an input already active at reset is not seen as an edge
    function automatic tlih_pkg::tlih_state_s rst_state();
        tlih_pkg::tlih_state_s s;
        s          = '0;
        s.cfg      = `TLIH_CFG_RST;
        s.prev_act = 2'b11;
        s.rdy      = 1'b1;
        return s;
    endfunction : rst_state

    localparam tlih_pkg::tlih_state_s ST_RST = rst_state();

    // Lowest rank among a mask of candidates wins
    function automatic logic [4:0] pick(input logic [11:0] mask);
        logic       found;
        logic [3:0] idx;
        logic [3:0] best;
        found = 1'b0;
        idx   = 4'h0;
        best  = 4'hf;
        for (int i = 0; i < NSRC; i++) begin
            if (mask[i] && (!found || SRC_RANK[i] < best)) begin
                found = 1'b1;
                idx   = 4'(i);
                best  = SRC_RANK[i];
            end
        end
        return {found, idx};
    endfunction : pick

    // Enable vector in source order
    function automatic logic [11:0] en_vec(input tlih_pkg::tlih_state_s s);
        return {s.eie, s.ie[5:0]};
    endfunction : en_vec

    // Priority vector in source order
    function automatic logic [11:0] pri_vec(input tlih_pkg::tlih_state_s s);
        return {s.eip, s.ip};
    endfunction : pri_vec

    // Register read decode; unmapped words read zero
    function automatic logic [31:0] rd_word(input tlih_pkg::tlih_state_s s,
                                            input logic [7:0]            a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            `TLIH_OFF_IRQ_ENABLE:       d[7:0]  = s.ie;
            `TLIH_OFF_IRQ_ENABLE_EXT:   d[5:0]  = s.eie;
            `TLIH_OFF_IRQ_PRIORITY:     d[7:0]  = {`TLIH_IP_UNUSED_BITS, s.ip};
            `TLIH_OFF_IRQ_PRIORITY_EXT: d[5:0]  = s.eip;
            `TLIH_OFF_TIMER_CONTROL: begin
                d[`TLIH_TC_EXT0_TRIG] = s.trig[0];
                d[`TLIH_TC_EXT0_PEND] = s.pend[`TLIH_SRC_EXT0];
                d[`TLIH_TC_EXT1_TRIG] = s.trig[1];
                d[`TLIH_TC_EXT1_PEND] = s.pend[`TLIH_SRC_EXT1];
            end
            `TLIH_OFF_EXT_IRQ_CONFIG:   d[7:0]  = s.cfg;
            `TLIH_OFF_PENDING:          d[11:0] = s.pend;
            `TLIH_OFF_STATUS:           d[7:0]  = {s.in_high, s.in_low, s.hold, s.req, s.sel};
            default:                    d       = 32'h0000_0000;
        endcase
        return d;
    endfunction : rd_word

    // ****************************************************************
    // State
    // ****************************************************************
    tlih_pkg::tlih_state_s s_r;
    tlih_pkg::tlih_state_s s_nxt;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic        pin0;
        logic        pin1;
        logic [1:0]  act;
        logic [1:0]  edg;
        logic [11:0] hw_set;
        logic [11:0] elig;
        logic [11:0] hi;
        logic [11:0] lo;
        logic [4:0]  hi_pick;
        logic [4:0]  lo_pick;
        logic        take;
        logic        clr_ok;
        logic [11:0] pv;
        pin0    = 1'b0;
        pin1    = 1'b0;
        act     = 2'b00;
        edg     = 2'b00;
        hw_set  = 12'h000;
        elig    = 12'h000;
        hi      = 12'h000;
        lo      = 12'h000;
        hi_pick = 5'h00;
        lo_pick = 5'h00;
        take    = 1'b0;
        clr_ok  = 1'b0;
        pv      = 12'h000;
        s_nxt   = s_r;
        s_nxt.vec.call = 1'b0;
        s_nxt.rdy      = 1'b1;
        s_nxt.resp     = 1'b0;

        // Write data phase; software clear loses to a same-cycle event below
        if (s_r.wr_pend) begin
            unique case (s_r.wr_addr)
                `TLIH_OFF_IRQ_ENABLE:       s_nxt.ie  = hwdata[7:0];
                `TLIH_OFF_IRQ_ENABLE_EXT:   s_nxt.eie = hwdata[5:0];
                `TLIH_OFF_IRQ_PRIORITY:     s_nxt.ip  = hwdata[5:0];
                `TLIH_OFF_IRQ_PRIORITY_EXT: s_nxt.eip = hwdata[5:0];
                `TLIH_OFF_TIMER_CONTROL: begin
                    s_nxt.trig[0] = hwdata[`TLIH_TC_EXT0_TRIG];
                    s_nxt.trig[1] = hwdata[`TLIH_TC_EXT1_TRIG];
                    s_nxt.pend[`TLIH_SRC_EXT0] = hwdata[`TLIH_TC_EXT0_PEND];
                    s_nxt.pend[`TLIH_SRC_EXT1] = hwdata[`TLIH_TC_EXT1_PEND];
                end
                `TLIH_OFF_EXT_IRQ_CONFIG:   s_nxt.cfg = hwdata[7:0];
                `TLIH_OFF_PENDING: begin
                    // External flags are reached through timer control only
                    for (int i = 0; i < NSRC; i++) begin
                        if (i != `TLIH_SRC_EXT0 && i != `TLIH_SRC_EXT1) begin
                            s_nxt.pend[i] = hwdata[i];
                        end
                    end
                end
                // Unmapped write offsets change nothing
                default: ;
            endcase
        end

        // Three select bits reach any of the eight port pins; the pin is
        // only read here, so whatever else uses it sees no extra load
        // Pin select taps the port only; nothing is driven back
        pin0 = port_pins[s_r.cfg[`TLIH_CFG_EXT0_SEL_LSB +: 3]];
        pin1 = port_pins[s_r.cfg[`TLIH_CFG_EXT1_SEL_LSB +: 3]];
        act[0] = s_r.cfg[`TLIH_CFG_EXT0_POL] ? pin0 : ~pin0;
        act[1] = s_r.cfg[`TLIH_CFG_EXT1_POL] ? pin1 : ~pin1;
        // Edge: active now, inactive one cycle before
        edg = act & ~s_r.prev_act;
        s_nxt.prev_act = act;

        // Vector taken at instruction end, one cycle after detection
        // Levels go through a local vector: a bit of a function result
        // cannot be selected directly
        pv   = pri_vec(s_r);
        take = instr_done && s_r.req && !s_r.hold;
        if (take) begin
            s_nxt.vec.call = 1'b1;
            s_nxt.vec.src  = s_r.sel;
            s_nxt.vec.addr = SRC_VEC[s_r.sel];
            s_nxt.vec.high = pv[s_r.sel];
            if (pv[s_r.sel]) begin
                s_nxt.in_high = 1'b1;
            end else begin
                s_nxt.in_low = 1'b1;
            end
            // Level-mode external flags are never auto-cleared
            clr_ok = 1'b1;
            if (s_r.sel == 4'(`TLIH_SRC_EXT0)) begin
                clr_ok = s_r.trig[0];
            end else if (s_r.sel == 4'(`TLIH_SRC_EXT1)) begin
                clr_ok = s_r.trig[1];
            end
            if (SRC_HWCLR[s_r.sel] && clr_ok) begin
                s_nxt.pend[s_r.sel] = 1'b0;
            end
        end

        // Hold lasts until the first ordinary instruction after a return,
        // so a request still pending waits exactly one instruction
        // Return pops the innermost level and holds one instruction
        if (return_from_interrupt_done) begin
            s_nxt.hold = 1'b1;
            if (s_r.in_high) begin
                s_nxt.in_high = 1'b0;
            end else begin
                s_nxt.in_low = 1'b0;
            end
        end else if (instr_done) begin
            s_nxt.hold = 1'b0;
        end

        // External sources come from the pins, never from src_event;
        // applied after clears so a same-cycle event wins over them
        // Hardware events set their flags whatever the enables
        hw_set = src_event;
        hw_set[`TLIH_SRC_EXT0] = s_r.trig[0] & edg[0];
        hw_set[`TLIH_SRC_EXT1] = s_r.trig[1] & edg[1];
        s_nxt.pend = s_nxt.pend | hw_set;

        // Applied last: a software write to a level-mode flag is lost in
        // the same cycle, the pin level is the only truth there
        // Level mode flag mirrors the active level
        if (!s_r.trig[0]) begin
            s_nxt.pend[`TLIH_SRC_EXT0] = act[0];
        end
        if (!s_r.trig[1]) begin
            s_nxt.pend[`TLIH_SRC_EXT1] = act[1];
        end

        // Decode every cycle; global enable gates all sources
        elig    = s_r.pend & en_vec(s_r) & {NSRC{s_r.ie[`TLIH_IE_GLOBAL]}};
        hi      = elig & pri_vec(s_r);
        lo      = elig & ~pri_vec(s_r);
        hi_pick = pick(hi);
        lo_pick = pick(lo);
        s_nxt.req = 1'b0;
        // A running low routine masks only low requests, so a high one
        // can still preempt it; nothing preempts a running high routine
        // High level wins; running high blocks all, running low blocks low
        if (hi_pick[4] && !s_r.in_high) begin
            s_nxt.req = !take;
            s_nxt.sel = hi_pick[3:0];
        end else if (lo_pick[4] && !s_r.in_high && !s_r.in_low) begin
            s_nxt.req = !take;
            s_nxt.sel = lo_pick[3:0];
        end
        // Request stays one cycle behind the enables, so a global clear in
        // the final cycle of an instruction may still admit one vector

        // Zero wait states: hreadyout never drops, so there is no stall
        // path; reading the next state lets a read right after a write
        // to the same word return the new value
        // AHB address phase; reads see this cycle's updates
        s_nxt.wr_pend = 1'b0;
        s_nxt.hrdata  = 32'h0000_0000;
        if (hsel && htrans[1] && hready) begin
            if (hwrite) begin
                s_nxt.wr_pend = 1'b1;
                s_nxt.wr_addr = haddr[7:0];
            end else begin
                s_nxt.hrdata = rd_word(s_nxt, haddr[7:0]);
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Priority bits leave reset at low level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Straight from the state flops
    assign hreadyout   = s_r.rdy;
    assign hresp       = s_r.resp;
    assign hrdata      = s_r.hrdata;
    assign irq_req     = s_r.req;
    assign vector_call = s_r.vec;

endmodule : tlih_irq_handler

// ---- tlih_core_model.sv ----
// Model of the core sequencer that completes instructions and returns
`timescale 1ns/1ps

module tlih_core_model (
    input  wire logic hclk,        // System clock
    input  wire logic hresetn,     // Reset, active low
    input  wire logic run,         // Core executes instructions
    input  wire logic slow,        // Multi-cycle instructions
    input  wire logic do_return_from_interrupt,     // Execute one return
    output logic      instr_done,  // Instruction completed
    output logic      return_from_interrupt_done    // Return completed
);
    // ****************************************************************
    // Instruction stream
    // ****************************************************************
    logic [1:0] cnt_r; // Cycles of a slow instruction

    // Slow mode stands for the two-byte opcode after a global clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r      <= 2'h0;
            instr_done <= 1'b0;
            return_from_interrupt_done  <= 1'b0;
        end else begin
            cnt_r      <= cnt_r + 2'h1;
            return_from_interrupt_done  <= do_return_from_interrupt; // Never together with instr_done
            instr_done <= !do_return_from_interrupt && run && (!slow || cnt_r == 2'h0);
        end
    end
endmodule : tlih_core_model

// ---- tlih_irq_handler_sva.sv ----
// Port checker for the interrupt handler
`timescale 1ns/1ps
`include "tlih_map.svh"

module tlih_irq_handler_sva #(
    parameter logic [11:0][15:0] SRC_VEC = `TLIH_VEC_DEFAULT // Service addresses
) (
    input wire logic                hclk,        // Clock
    input wire logic                hresetn,     // Reset, active low
    input wire logic                hsel,        // Select
    input wire logic [1:0]          htrans,      // Transfer type
    input wire logic                hwrite,      // Write
    input wire logic                hready,      // Bus ready
    input wire logic                hreadyout,   // Slave ready
    input wire logic                hresp,       // Response
    input wire logic [31:0]         hrdata,      // Read data
    input wire logic                instr_done,  // Instruction done
    input wire logic                return_from_interrupt_done,   // Return done
    input wire logic                irq_req,     // Request
    input wire tlih_pkg::tlih_vec_s vector_call  // Vector call
);
    // ****************************************************************
    // Helper and assertions
    // ****************************************************************
    logic hold_r; // Return seen, no instruction since

    // Mirrors the one-instruction hold after a return
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hold_r <= 1'b0;
        else if (return_from_interrupt_done) hold_r <= 1'b1;
        else if (instr_done) hold_r <= 1'b0;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence take_s;
        irq_req && instr_done && !hold_r;
    endsequence
    sequence call_s;
        vector_call.call ##1 !vector_call.call;
    endsequence

    take_call_a: assert property (take_s |=> call_s)
        else $error("Admissible request was not taken");
    call_cause_a: assert property (vector_call.call |-> $past(irq_req && instr_done))
        else $error("Vector call without request");
    req_drop_a: assert property (vector_call.call |-> !irq_req)
        else $error("Request high during call");
    hold_skip_a: assert property (hold_r && instr_done |=> !vector_call.call)
        else $error("Call inside return hold");
    vec_addr_a: assert property (vector_call.call |->
        vector_call.addr == SRC_VEC[vector_call.src]) else $error("Wrong service address");
    vec_keep_a: assert property (!vector_call.call |->
        $stable({vector_call.high, vector_call.src, vector_call.addr}))
        else $error("Vector fields moved without call");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("Slave not ready or not OKAY");
    rd_idle_a: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |->
        hrdata == 32'h0) else $error("Read data outside data phase");
endmodule : tlih_irq_handler_sva

bind tlih_irq_handler tlih_irq_handler_sva #(.SRC_VEC(SRC_VEC)) i_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .instr_done(instr_done), .return_from_interrupt_done(return_from_interrupt_done), .irq_req(irq_req),
    .vector_call(vector_call)
);

// ---- tlih_irq_handler_tb_top.sv ----
// Self-checking bench for the interrupt handler
`timescale 1ns/1ps

module tlih_irq_handler_tb_top;
    logic                hclk = 1'b0;
    logic                hresetn = 1'b0;
    logic                hsel = 1'b0;
    logic                hwrite = 1'b0;
    logic                run = 1'b0;
    logic                slow = 1'b0;
    logic                do_return_from_interrupt = 1'b0;
    logic                rd_dp = 1'b0;
    logic [1:0]          htrans = 2'h0;
    logic [31:0]         haddr = 32'h0;
    logic [31:0]         hwdata = 32'h0;
    logic [7:0]          port_pins = 8'hff;
    logic [11:0]         src_event = 12'h000;
    logic [7:0]          p;
    logic [7:0]          c;
    logic                hreadyout, hresp, irq_req, instr_done, return_from_interrupt_done;
    logic [31:0]         hrdata;
    tlih_pkg::tlih_vec_s vector_call;
    logic [31:0]         rd_q[$];
    logic [20:0]         vec_q[$];
    logic [7:0]          offs[7] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
    int                  failures = 0;
    int                  n_compared = 0;
    int                  cyc = 0;
    integer              seed = 32'h62c4bd15;

    tlih_irq_handler i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_pins(port_pins),
        .src_event(src_event), .instr_done(instr_done), .return_from_interrupt_done(return_from_interrupt_done),
        .irq_req(irq_req), .vector_call(vector_call)
    );
    tlih_core_model i_core (
        .hclk(hclk), .hresetn(hresetn), .run(run), .slow(slow), .do_return_from_interrupt(do_return_from_interrupt),
        .instr_done(instr_done), .return_from_interrupt_done(return_from_interrupt_done)
    );

    // ****************************************************************
    // Clock, watchers and tasks
    // ****************************************************************
    always #12.5 hclk = ~hclk;

    task close_out();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    task chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk32

    task chkv(input logic [20:0] exp);
        chk32("vector", {11'h0, exp}, {11'h0, vector_call.high, vector_call.src, vector_call.addr});
    endtask : chkv

    // Long waits end here as a mismatch
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end

    // Oldest note is compared whenever a result appears
    always @(posedge hclk) begin
        if (rd_dp === 1'b1) chk32("hrdata", rd_q.pop_front(), hrdata);
        if (vector_call.call === 1'b1) begin
            if (vec_q.size() == 0) chk32("unexpected call", 32'h0, 32'h1);
            else chkv(vec_q.pop_front());
        end
    end

    // One transfer; entered right after an edge, left right after one
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hwdata <= ~d; // Released bus shows no stale data
        rd_dp <= 1'b0;
    endtask : ahb

    task wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        ahb(1'b0, a, 32'h0);
    endtask : rd

    task exp_v(input logic [3:0] s, input logic h);
        vec_q.push_back({h, s, 16'h0003 + {9'h0, s, 3'h0}});
    endtask : exp_v

    task wait_n(input int n);
        repeat (80) if (vec_q.size() > n) @(posedge hclk);
    endtask : wait_n

    task ev(input int i);
        src_event[i] <= 1'b1;
        @(posedge hclk);
        src_event <= 12'h000;
        @(posedge hclk);
    endtask : ev

    task ret();
        do_return_from_interrupt <= 1'b1;
        @(posedge hclk);
        do_return_from_interrupt <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask : ret

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 7; i++) rd(offs[i], (offs[i] == 8'h08) ? 32'hc0 : 32'h0);
        $display("Test reset values done");
        run <= 1'b1;
        ev(4);
        repeat (4) @(posedge hclk);
        chk32("irq_req", 32'h0, {31'h0, irq_req});
        rd(8'h18, 32'h10);
        wr(8'h00, 32'h10);
        repeat (4) @(posedge hclk);
        chk32("irq_req", 32'h0, {31'h0, irq_req});
        exp_v(4'h4, 1'b0);
        wr(8'h00, 32'h90);
        wait_n(0);
        wr(8'h18, 32'h0);
        ret();
        $display("Test enables done");
        run <= 1'b0;
        wr(8'h00, 32'h8a);
        wr(8'h08, 32'h08);
        exp_v(4'h3, 1'b1);
        exp_v(4'h1, 1'b0);
        wr(8'h18, 32'h0a);
        slow <= 1'b1;
        run <= 1'b1;
        wait_n(1);
        repeat (8) @(posedge hclk);
        chk32("irq_req", 32'h0, {31'h0, irq_req});
        chk32("calls left", 32'h1, 32'(vec_q.size()));
        rd(8'h18, 32'h002);
        ret();
        wait_n(0);
        exp_v(4'h3, 1'b1);
        wr(8'h18, 32'h08);
        wait_n(0);
        ret();
        ret();
        rd(8'h18, 32'h0);
        slow <= 1'b0;
        $display("Test priorities done");
        run <= 1'b0;
        port_pins <= 8'hfe;
        wr(8'h14, 32'h08);
        wr(8'h10, 32'h01);
        wr(8'h00, 32'h81);
        port_pins <= 8'hff; // Pin stays active until the call
        repeat (3) @(posedge hclk);
        rd(8'h10, 32'h03);
        exp_v(4'h0, 1'b0);
        run <= 1'b1;
        wait_n(0);
        rd(8'h10, 32'h01);
        ret();
        $display("Test edge input done");
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h0);
        for (int i = 0; i < 6; i++) begin
            {c, p} = 16'($random(seed));
            port_pins <= p;
            wr(8'h14, {24'h0, c});
            repeat (2) @(posedge hclk);
            rd(8'h10, {28'h0, p[c[6:4]] == c[7], 1'b0, p[c[2:0]] == c[3], 1'b0});
        end
        $display("Test level inputs done");
        wait_n(0);
        chk32("calls left", 32'h0, 32'(vec_q.size()));
        close_out();
    end
endmodule : tlih_irq_handler_tb_top
